// File: shared/parallel_port_pkg.sv
package parallel_port_pkg;

    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_PIN_EN = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RDIN = 8'h0c;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_ADDR = 8'h14;
    localparam logic [7:0] OFS_DATA = 8'h18;
    localparam logic [7:0] OFS_SLOT = 8'h20;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int POS_SPLIT = 17;
    localparam int POS_MUX = 11;
    localparam int POS_CSF = 6;
    localparam int POS_OVERFLOW = 14;
    localparam int POS_UNDERFLOW = 6;
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] PIN_EN_RESET = 16'h0000;
    localparam logic [3:0] OUT_EMPTY_RESET = 4'hf;

    // ****************************************
    // timing: one wait unit is one peripheral clock
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int PERIPH_CLOCK_PERIOD_NS = 4;
    localparam int PERIPH_CYCLES = (PERIPH_CLOCK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // field codes
    // ****************************************
    localparam logic [1:0] PM_LEGACY = 2'h0;
    localparam logic [1:0] PM_ENHANCED = 2'h1;
    localparam logic [1:0] PM_MASTER2 = 2'h2;
    localparam logic [1:0] PM_MASTER1 = 2'h3;
    localparam logic [1:0] IRQ_NONE = 2'h0;
    localparam logic [1:0] IRQ_CYCLE = 2'h1;
    localparam logic [1:0] IRQ_SLOT3 = 2'h2;
    localparam logic [1:0] STEP_HOLD = 2'h0;
    localparam logic [1:0] STEP_INC = 2'h1;
    localparam logic [1:0] STEP_DEC = 2'h2;
    localparam logic [1:0] STEP_AUTO = 2'h3;

    typedef struct packed {
        logic busy;
        logic [1:0] irq_request_select;
        logic [1:0] addr_step_select;
        logic wide_transfer;
        logic [1:0] port_mode;
        logic [1:0] wait_begin;
        logic [3:0] wait_middle;
        logic [1:0] wait_end;
    } mode_t;

    typedef struct packed {
        logic input_all_full;
        logic input_overflow;
        logic [1:0] unused_hi;
        logic [3:0] input_slot_full;
        logic output_all_empty;
        logic output_underflow;
        logic [1:0] unused_lo;
        logic [3:0] output_slot_empty;
    } status_t;

    typedef enum logic [1:0] {ST_IDLE, ST_BEGIN, ST_MIDDLE, ST_END} xfer_state_t;

endpackage

// File: hdl/parallel_port_mode_status.sv
// Contract
// - busy flag shows master cycle in progress
// - irq mode 01 pulses per cycle end
// - irq mode 10 on buffer 3 access
// - step mode increments or decrements address
// - step 11 advances legacy slave pointers
// - chip-select pads excluded from stepping
// - each data access starts one transfer
// - master modes drive their strobe sets
// - slave modes take host strobes, address
// - begin wait sets 1..4 clock setup
// - middle wait zero forces fixed waits
// - upper data byte only when wide
// - pad enables 15:14 give chip selects
// - pad enables 13:2 give address lines
// - pad enables 1:0 give latch strobes
// - input full when all slots full
// - host write to full slot sets overflow
// - slot full set by host, cleared reading
// - output empty when all slots empty
// - host read of empty slot sets underflow
// - slot empty cleared writing, set by host
// - split buffer routes reads to read register
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module parallel_port_mode_status
    import parallel_port_pkg::*;
(
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // unmapped address
    input wire logic [15:0] data_pad_in, // data pad levels
    output logic [15:0] data_pad_out, // data pad drive
    output logic [15:0] data_pad_oe, // data pad enable
    input wire logic [1:0] addr_pad_in, // slave address pads
    output logic [15:0] addr_pad_out, // address pad drive
    output logic [15:0] addr_pad_oe, // address pad enable
    output logic [1:0] chip_select_out, // master chip selects
    output logic read_strobe, // read or direction strobe
    output logic write_strobe, // write strobe
    output logic enable_strobe, // enable strobe
    input wire logic host_read, // slave read strobe in
    input wire logic host_write, // slave write strobe in
    input wire logic host_select, // slave chip select in
    output logic irq_pulse // port event pulse
);

    // ****************************************
    // state
    // ****************************************
    mode_t mode_q;
    logic [15:0] pin_en_q, addr_q, wdata_q, din_q, rdin_q;
    logic split_q;
    logic [1:0] csf_q, mux_q;
    logic [7:0] in_buf [4];
    logic [7:0] out_buf [4];
    logic [3:0] in_full_q, out_empty_q;
    logic overflow_q, underflow_q;
    logic [1:0] wr_ptr_q, rd_ptr_q;
    logic host_wr_prev_q, host_rd_prev_q;
    xfer_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic is_rd_q, rd_d, xfer_done;
    logic pready_q;

    // ****************************************
    // phase lengths in bus clocks
    // ****************************************
    function automatic logic [3:0] phase_len(input xfer_state_t ph, input mode_t m,
                                             input logic rd);
        logic [3:0] n;
        n = 4'h1;
        if (m.wait_middle == 4'h0) begin
            if (ph == ST_END && rd) begin
                n = 4'h0;
            end
        end else begin
            unique case (ph)
                ST_BEGIN: n = {2'b00, m.wait_begin} + 4'h1;
                ST_MIDDLE: n = m.wait_middle;
                ST_END: n = {2'b00, m.wait_end} + 4'h1;
                default: n = 4'h1;
            endcase
        end
        return 4'(n * PERIPH_CYCLES);
    endfunction

    function automatic logic [15:0] step_addr(input logic [15:0] a, input logic [1:0] s,
                                              input logic keep_top);
        logic [15:0] n;
        n = a;
        if (s == STEP_INC) begin
            n = a + 16'h1;
        end else if (s == STEP_DEC) begin
            n = a - 16'h1;
        end
        if (keep_top) begin
            n[15:14] = a[15:14];
        end
        return n;
    endfunction

    // ****************************************
    // apb decode
    // ****************************************
    logic setup, acc, slot_hit, hit, master_on, slave_buf;
    logic wr_data, rd_trig, start, sw_rd_slot, sw_wr_slot;
    logic [1:0] sidx;
    logic [31:0] rdata;
    mode_t mode_rd;
    status_t st;

    assign setup = psel && !penable;
    assign acc = psel && penable && pready_q;
    assign slot_hit = {paddr[7:4], 4'h0} == OFS_SLOT && paddr[1:0] == 2'b00;
    assign sidx = paddr[3:2];
    assign master_on = mode_q.port_mode[1];
    assign slave_buf = mode_q.port_mode == PM_LEGACY && mode_q.addr_step_select == STEP_AUTO;
    assign wr_data = acc && pwrite && paddr == OFS_DATA;
    assign rd_trig = acc && !pwrite &&
                     ((paddr == OFS_DATA && !split_q) || (paddr == OFS_RDIN && split_q));
    assign start = master_on && state_q == ST_IDLE && (wr_data || rd_trig);
    assign sw_rd_slot = acc && !pwrite && slot_hit;
    assign sw_wr_slot = acc && pwrite && slot_hit;

    always_comb begin
        mode_rd = mode_q;
        mode_rd.busy = state_q != ST_IDLE;
        st = '0;
        st.input_all_full = &in_full_q;
        st.input_overflow = overflow_q;
        st.input_slot_full = in_full_q;
        st.output_all_empty = &out_empty_q;
        st.output_underflow = underflow_q;
        st.output_slot_empty = out_empty_q;
        hit = 1'b1;
        rdata = '0;
        if (slot_hit) begin
            rdata = {24'h0, in_buf[sidx]};
        end else begin
            case (paddr)
                OFS_MODE: rdata = {16'h0, mode_rd};
                OFS_PIN_EN: rdata = {16'h0, pin_en_q};
                OFS_STATUS: rdata = {16'h0, st};
                OFS_RDIN: rdata = {16'h0, rdin_q};
                OFS_CTRL: begin
                    rdata[POS_SPLIT] = split_q;
                    rdata[POS_MUX +: 2] = mux_q;
                    rdata[POS_CSF +: 2] = csf_q;
                end
                OFS_ADDR: rdata = {16'h0, addr_q};
                OFS_DATA: rdata = {16'h0, din_q};
                default: hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready_q <= setup;
            if (setup) begin
                prdata <= rdata;
                pslverr <= !hit;
            end
        end
    end
    assign pready = pready_q;

    // ****************************************
    // software registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_RESET;
            pin_en_q <= PIN_EN_RESET;
            split_q <= 1'b0;
            csf_q <= 2'b00;
            mux_q <= 2'b00;
            wdata_q <= '0;
        end else if (acc && pwrite) begin
            case (paddr)
                OFS_MODE: mode_q <= mode_t'({1'b0, pwdata[14:0]});
                OFS_PIN_EN: pin_en_q <= pwdata[15:0];
                OFS_CTRL: begin
                    split_q <= pwdata[POS_SPLIT];
                    mux_q <= pwdata[POS_MUX +: 2];
                    csf_q <= pwdata[POS_CSF +: 2];
                end
                OFS_DATA: wdata_q <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // master cycle sequencer
    // ****************************************
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        xfer_done = 1'b0;
        rd_d = start ? !pwrite : is_rd_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_BEGIN;
                    cnt_d = phase_len(ST_BEGIN, mode_q, !pwrite) - 4'h1;
                end
            end
            ST_BEGIN: begin
                if (cnt_q == 4'h0) begin
                    state_d = ST_MIDDLE;
                    cnt_d = phase_len(ST_MIDDLE, mode_q, is_rd_q) - 4'h1;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            ST_MIDDLE: begin
                if (cnt_q != 4'h0) begin
                    cnt_d = cnt_q - 4'h1;
                end else if (phase_len(ST_END, mode_q, is_rd_q) == 4'h0) begin
                    state_d = ST_IDLE;
                    xfer_done = 1'b1;
                end else begin
                    state_d = ST_END;
                    cnt_d = phase_len(ST_END, mode_q, is_rd_q) - 4'h1;
                end
            end
            ST_END: begin
                if (cnt_q == 4'h0) begin
                    state_d = ST_IDLE;
                    xfer_done = 1'b1;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            is_rd_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            is_rd_q <= rd_d;
        end
    end

    // address register, hardware step wins over software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= '0;
        end else if (xfer_done) begin
            addr_q <= step_addr(addr_q, mode_q.addr_step_select, csf_q != 2'b00);
        end else if (acc && pwrite && paddr == OFS_ADDR) begin
            addr_q <= pwdata[15:0];
        end
    end

    // read data sampled at the end of the strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_q <= '0;
            rdin_q <= '0;
        end else if (state_q == ST_MIDDLE && cnt_q == 4'h0 && is_rd_q) begin
            if (split_q) begin
                rdin_q <= mode_q.wide_transfer ? data_pad_in : {8'h00, data_pad_in[7:0]};
            end else begin
                din_q <= mode_q.wide_transfer ? data_pad_in : {8'h00, data_pad_in[7:0]};
            end
        end else if (acc && pwrite && paddr == OFS_RDIN) begin
            rdin_q <= pwdata[15:0];
        end
    end

    // ****************************************
    // slave buffers
    // ****************************************
    logic slave_on, wr_ev, rd_ev, slot3_ev;
    logic [1:0] widx, ridx;

    assign slave_on = !master_on;
    assign wr_ev = slave_on && host_write && host_select && !host_wr_prev_q;
    assign rd_ev = slave_on && host_read && host_select && !host_rd_prev_q;
    assign widx = mode_q.port_mode == PM_ENHANCED ? addr_pad_in : (slave_buf ? wr_ptr_q : 2'd0);
    assign ridx = mode_q.port_mode == PM_ENHANCED ? addr_pad_in : (slave_buf ? rd_ptr_q : 2'd0);
    assign slot3_ev = (mode_q.port_mode == PM_ENHANCED || slave_buf) &&
                      ((wr_ev && widx == 2'd3) || (rd_ev && ridx == 2'd3));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_wr_prev_q <= 1'b0;
            host_rd_prev_q <= 1'b0;
            wr_ptr_q <= 2'd0;
            rd_ptr_q <= 2'd0;
        end else begin
            host_wr_prev_q <= host_write && host_select;
            host_rd_prev_q <= host_read && host_select;
            if (wr_ev && slave_buf) begin
                wr_ptr_q <= wr_ptr_q + 2'd1;
            end
            if (rd_ev && slave_buf) begin
                rd_ptr_q <= rd_ptr_q + 2'd1;
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (wr_ev) begin
            in_buf[widx] <= data_pad_in[7:0];
        end
        if (sw_wr_slot) begin
            out_buf[sidx] <= pwdata[7:0];
        end
    end

    // hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_full_q <= 4'h0;
            out_empty_q <= OUT_EMPTY_RESET;
            overflow_q <= 1'b0;
            underflow_q <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_ev && widx == 2'(i)) begin
                    in_full_q[i] <= 1'b1;
                end else if (sw_rd_slot && sidx == 2'(i)) begin
                    in_full_q[i] <= 1'b0;
                end
                if (rd_ev && ridx == 2'(i)) begin
                    out_empty_q[i] <= 1'b1;
                end else if (sw_wr_slot && sidx == 2'(i)) begin
                    out_empty_q[i] <= 1'b0;
                end
            end
            if (wr_ev && in_full_q[widx]) begin
                overflow_q <= 1'b1;
            end else if (acc && pwrite && paddr == OFS_STATUS && !pwdata[POS_OVERFLOW]) begin
                overflow_q <= 1'b0;
            end
            if (rd_ev && out_empty_q[ridx]) begin
                underflow_q <= 1'b1;
            end else if (acc && pwrite && paddr == OFS_STATUS && !pwdata[POS_UNDERFLOW]) begin
                underflow_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // pins, registered from next state
    // ****************************************
    logic active_d, strobe_d, cs1_d, cs2_d;

    assign active_d = state_d != ST_IDLE;
    assign strobe_d = state_d == ST_MIDDLE;
    assign cs1_d = active_d && csf_q != 2'b00 && pin_en_q[14];
    assign cs2_d = active_d && csf_q == 2'b10 && pin_en_q[15];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_strobe <= 1'b0;
            write_strobe <= 1'b0;
            enable_strobe <= 1'b0;
            chip_select_out <= 2'b00;
            addr_pad_out <= '0;
            addr_pad_oe <= '0;
            data_pad_out <= '0;
            data_pad_oe <= '0;
            irq_pulse <= 1'b0;
        end else begin
            read_strobe <= master_on && ((mode_q.port_mode == PM_MASTER2 && strobe_d && rd_d) ||
                           (mode_q.port_mode == PM_MASTER1 && active_d && rd_d));
            write_strobe <= master_on && mode_q.port_mode == PM_MASTER2 && strobe_d && !rd_d;
            enable_strobe <= master_on && mode_q.port_mode == PM_MASTER1 && strobe_d;
            chip_select_out <= {cs2_d, cs1_d};
            addr_pad_oe <= master_on ? pin_en_q : 16'h0000;
            addr_pad_out <= addr_q;
            if (csf_q != 2'b00) begin
                addr_pad_out[15:14] <= {cs2_d, cs1_d};
            end
            if (mux_q != 2'b00) begin
                addr_pad_out[1:0] <= {mux_q == 2'b10 && state_d == ST_BEGIN,
                                      state_d == ST_BEGIN};
            end
            if (master_on) begin
                data_pad_oe <= (active_d && !rd_d) ?
                               {{8{mode_q.wide_transfer}}, 8'hff} : 16'h0000;
                data_pad_out <= (state_d == ST_BEGIN && mux_q != 2'b00) ? addr_q : wdata_q;
            end else begin
                data_pad_oe <= (host_read && host_select) ? 16'h00ff : 16'h0000;
                if (rd_ev) begin
                    data_pad_out <= {8'h00, out_buf[ridx]};
                end
            end
            irq_pulse <= (mode_q.irq_request_select == IRQ_CYCLE && xfer_done) ||
                         (mode_q.irq_request_select == IRQ_SLOT3 && slot3_ev);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_plain_begin;
        state_q == ST_BEGIN ##1 state_q == ST_MIDDLE;
    endsequence

    sequence s_long_begin;
        (state_q == ST_BEGIN) [*4] ##1 state_q == ST_MIDDLE;
    endsequence

    a_busy_on_start: assert property (start |=> mode_rd.busy)
        else $error("busy not raised after start");
    a_busy_drop: assert property (xfer_done |=> !mode_rd.busy && state_q == ST_IDLE)
        else $error("busy still set after cycle");
    a_irq_cycle: assert property (xfer_done && mode_q.irq_request_select == IRQ_CYCLE
                                  |=> irq_pulse)
        else $error("no irq at cycle end");
    a_irq_off: assert property (irq_pulse |-> $past(mode_q.irq_request_select) != IRQ_NONE)
        else $error("irq while mode none");
    a_irq_slot3: assert property (slot3_ev && mode_q.irq_request_select == IRQ_SLOT3
                                  |=> irq_pulse)
        else $error("no irq on buffer 3 access");
    a_addr_inc: assert property (xfer_done && mode_q.addr_step_select == STEP_INC &&
                                 csf_q == 2'b00 && !(acc && pwrite)
                                 |=> addr_q == $past(addr_q) + 16'h1)
        else $error("address not incremented");
    a_top_kept: assert property (xfer_done && csf_q != 2'b00
                                 |=> addr_q[15:14] == $past(addr_q[15:14]))
        else $error("chip select bits stepped");
    a_ptr_step: assert property (wr_ev && slave_buf |=> wr_ptr_q == $past(wr_ptr_q) + 2'd1)
        else $error("write pointer not advanced");
    a_plain_wait: assert property (start && mode_q.wait_middle == 4'h0 |=> s_plain_begin)
        else $error("plain begin wait wrong");
    a_long_wait: assert property (start && mode_q.wait_middle != 4'h0 &&
                                  mode_q.wait_begin == 2'b11 |=> s_long_begin)
        else $error("begin wait not four clocks");
    a_upper_quiet: assert property (data_pad_oe[15:8] != 8'h00
                                    |-> $past(mode_q.wide_transfer))
        else $error("upper byte driven in narrow mode");
    a_strobe_kind: assert property (enable_strobe |-> $past(mode_q.port_mode) == PM_MASTER1)
        else $error("enable strobe outside master 1");
    a_pad_gate: assert property ((addr_pad_oe & ~$past(pin_en_q)) == 16'h0000)
        else $error("address pad driven while disabled");
    a_ovf_set: assert property (wr_ev && in_full_q[widx] |=> overflow_q)
        else $error("overflow not flagged");
    a_slot_full: assert property (wr_ev |=> in_full_q[$past(widx)])
        else $error("input slot not marked full");
    a_slot_empty: assert property (rd_ev |=> out_empty_q[$past(ridx)] && irq_pulse ==
                                   $past(mode_q.irq_request_select == IRQ_SLOT3 && slot3_ev))
        else $error("output slot not marked empty");
    a_unf_set: assert property (rd_ev && out_empty_q[ridx] |=> underflow_q)
        else $error("underflow not flagged");

endmodule

// File: test/host_model.sv
`timescale 1ns/1ns
module host_model (
    input wire logic pclk, // bus clock
    input wire logic [15:0] data_pad_out, // port drive
    output logic host_read, // read strobe
    output logic host_write, // write strobe
    output logic host_select, // chip select
    output logic [1:0] addr_pad_in, // slot address
    output logic [15:0] data_pad_in // pad levels
);
    initial begin
        {host_read, host_write, host_select, addr_pad_in} = '0;
        data_pad_in = 16'h5a5a;
    end
    // one strobe; released data pads never keep the old value
    task automatic access(input logic wr, input logic [1:0] s, input logic [7:0] b,
                          output logic [7:0] q);
        @(posedge pclk);
        addr_pad_in <= s;
        data_pad_in <= {8'h00, b};
        host_select <= 1'b1;
        host_write <= wr;
        host_read <= !wr;
        repeat (3) @(posedge pclk);
        q = data_pad_out[7:0];
        {host_read, host_write, host_select} <= 3'b000;
        data_pad_in <= ~data_pad_in;
    endtask
endmodule

// File: test/parallel_port_mode_status_tb.sv
`timescale 1ns/1ns
module parallel_port_mode_status_tb;
    import parallel_port_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic pready, pslverr, err, host_read, host_write, host_select, irq_pulse, write_strobe;
    logic enable_strobe;
    logic [1:0] addr_pad_in, chip_select_out;
    logic [15:0] data_pad_in, data_pad_out, a;
    logic [7:0] q, sent[$];
    int miscompares = 0, checks_done = 0, cyc = 0, irqs = 0, strobes = 0, ens = 0, css = 0;
    parallel_port_mode_status u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .data_pad_in, .data_pad_out, .data_pad_oe(),
        .addr_pad_in, .addr_pad_out(), .addr_pad_oe(), .chip_select_out, .read_strobe(),
        .write_strobe, .enable_strobe, .host_read, .host_write, .host_select, .irq_pulse);
    host_model u_host (.pclk, .data_pad_out, .host_read, .host_write, .host_select,
        .addr_pad_in, .data_pad_in);
    initial forever #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (irq_pulse === 1'b1) irqs++;
        if (write_strobe === 1'b1) strobes++;
        if (enable_strobe === 1'b1) ens++;
        if (chip_select_out[0] === 1'b1) css++;
        if (cyc == 4000) begin
            miscompares++;
            complete_run();
        end
    end
    // ****************************************
    // bus tasks
    // ****************************************
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d, miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(34));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFS_STATUS, 0);
        chk(r, 32'h0000008f);
        apb(0, 8'h40, 0);
        chk({31'h0, err}, 32'h1);
        a = 16'($urandom);
        apb(1, OFS_PIN_EN, {16'h0, a});
        apb(0, OFS_PIN_EN, 0);
        chk(r, {16'h0, a});
        // master 2 write, begin wait 4, middle wait 3, hold/inc/dec
        for (int s = 0; s < 3; s++) begin
            apb(1, OFS_MODE, 32'h22cc | (s << 11));
            apb(1, OFS_ADDR, {16'h0, a});
            apb(1, OFS_DATA, $urandom);
            apb(0, OFS_MODE, 0);
            chk(r & 32'h8000, 32'h8000);
            repeat (12) @(posedge pclk);
            apb(0, OFS_MODE, 0);
            chk(r & 32'h8000, 32'h0);
            apb(0, OFS_ADDR, 0);
            chk(r, {16'h0, 16'(a + (s == 1) - (s == 2))});
            chk(irqs, s + 1);
            chk(strobes, 3 * (s + 1));
        end
        // master 1 read, plain waits, split buffer, chip selects 2 and 1
        apb(1, OFS_CTRL, 32'h00020080);
        apb(1, OFS_MODE, 32'h2f00);
        apb(1, OFS_ADDR, {16'h0, a});
        apb(0, OFS_RDIN, 0);
        repeat (4) @(posedge pclk);
        apb(0, OFS_ADDR, 0);
        chk(r, {16'h0, a[15:14], 14'(a[13:0] + 14'h1)});
        chk(ens, 1);
        chk(css, 2 * a[14]);
        apb(0, OFS_RDIN, 0);
        chk(r, 32'h5a5a);
        chk(irqs, 4);
        // enhanced slave with slot 3 events
        apb(1, OFS_MODE, 32'h4100);
        u_host.access(1, 2'd3, a[7:0], q);
        apb(0, OFS_STATUS, 0);
        chk(r, 32'h088f);
        chk(irqs, 6);
        u_host.access(1, 2'd3, a[15:8], q);
        apb(0, OFS_STATUS, 0);
        chk(r, 32'h488f);
        apb(0, OFS_SLOT + 8'h0c, 0);
        chk(r, {24'h0, a[15:8]});
        apb(1, OFS_STATUS, 0);
        u_host.access(0, 2'd1, 8'h00, q);
        sent.push_back(a[7:0]);
        apb(1, OFS_SLOT, {24'h0, sent[0]});
        apb(0, OFS_STATUS, 0);
        chk(r, 32'h004e);
        u_host.access(0, 2'd0, 8'h00, q);
        chk({24'h0, q}, {24'h0, sent.pop_front()});
        apb(0, OFS_STATUS, 0);
        chk(r, 32'h00cf);
        // legacy slave, auto pointers pick the slot
        apb(1, OFS_MODE, 32'h1800);
        repeat (2) u_host.access(1, 2'd3, 8'h00, q);
        apb(0, OFS_STATUS, 0);
        chk(r, 32'h03cf);
        complete_run();
    end
endmodule
